// ### core/pfs_pkg.sv
// Purpose: Shared constants and types for the port C/D/E function select block
// Assumes: Byte-wide register port, 250 MHz MCLK
// Notes:   Register indices are byte addresses on the plain port
package pfs_pkg;
    localparam logic [3:0] ADDR_PC_SEL_LOW   = 4'h0;
    localparam logic [3:0] ADDR_PC_SEL_HIGH  = 4'h1;
    localparam logic [3:0] ADDR_PD_SEL_LOW   = 4'h2;
    localparam logic [3:0] ADDR_PD_SEL_HIGH  = 4'h3;
    localparam logic [3:0] ADDR_PE_SEL_LOW   = 4'h4;
    localparam logic [3:0] ADDR_PE_SEL_HIGH  = 4'h5;
    localparam logic [3:0] ADDR_SHARE        = 4'h6;
    localparam logic [3:0] ADDR_PC_DATA      = 4'h8;
    localparam logic [3:0] ADDR_PC_DIR       = 4'h9;
    localparam logic [3:0] ADDR_PD_DATA      = 4'ha;
    localparam logic [3:0] ADDR_PD_DIR       = 4'hb;
    localparam logic [3:0] ADDR_PE_DATA      = 4'hc;
    localparam logic [3:0] ADDR_PE_DIR       = 4'hd;
    localparam logic [3:0] ADDR_PA_WAKE_EN   = 4'he;
    localparam logic [3:0] ADDR_BIT_OP       = 4'hf;

    localparam logic [7:0] SEL_RESET         = 8'h00;
    localparam logic [7:0] PORT_RESET        = 8'hff;
    localparam logic [7:0] WAKE_RESET        = 8'h00;
    localparam logic [7:0] PE_HIGH_MASK      = 8'h0f;
    localparam logic [7:0] SHARE_MASK        = 8'h03;
    localparam logic [7:0] PE_MASK           = 8'h3f;

    localparam logic [1:0] CODE_ALT          = 2'b01;
    localparam logic [1:0] CODE_ALT2         = 2'b10;

    localparam int         SHARE_LINE5_BIT   = 1;
    localparam int         SHARE_LINE4_BIT   = 0;

    // Bit operation word: [7] set(1)/clear(0), [6:4] bit index, [3:0] target address
    localparam int         BITOP_SET_POS     = 7;
    localparam int         BITOP_IDX_POS     = 4;

    typedef enum logic [1:0] {
        FN_GPIO,
        FN_SEGMENT,
        FN_COMMON,
        FN_TIMER
    } pfs_func_t;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
    } pfs_port_t;

    typedef struct packed {
        logic       sel;
        logic       drive;
        logic       out_en;
    } pfs_pin_t;
endpackage

// ### core/pfs_gpio_pin.sv
// Purpose: One general purpose pin driver with alternate function override
// Assumes: Direction bit high means input
// Notes:   Alternate function takes the pad when selected
`timescale 1ns/1ns
`default_nettype none
module pfs_gpio_pin (
    input  wire logic       data_bit,
    input  wire logic       dir_bit,
    input  wire logic       alt_sel,
    input  wire logic       alt_drive,
    output pfs_pkg::pfs_pin_t pin
);
    import pfs_pkg::*;
    always_comb begin
        pin.sel    = alt_sel;
        pin.drive  = alt_sel ? alt_drive : data_bit;
        pin.out_en = alt_sel ? 1'b1 : ~dir_bit;
    end
endmodule
`default_nettype wire

// ### core/pfs_wake_detect.sv
// Purpose: Port A falling-edge wake-up detector
// Assumes: Pins are asynchronous to MCLK
// Notes:   Wake pulse only while the low-power request is high
`timescale 1ns/1ns
`default_nettype none
module pfs_wake_detect (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] pins,
    input  wire logic [7:0] enable,
    input  wire logic       low_power,
    output logic            wake
);
    import pfs_pkg::*;
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= PORT_RESET;
            sync_b <= PORT_RESET;
            prev   <= PORT_RESET;
        end else begin
            sync_a <= pins;
            sync_b <= sync_a;
            prev   <= sync_b;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake <= 1'b0;
        end else begin
            wake <= low_power && |(prev & ~sync_b & enable);
        end
    end
endmodule
`default_nettype wire

// ### core/pfs_top.sv
// Purpose: Pin function selection for ports C, D and E, with port registers and port A wake
// Assumes: Byte register port, read data valid the cycle after the read strobe
// Notes:   Pad outputs are registered; alternate sources come from timer and LCD logic
// Functional notes
// - PC0 field: 01 timer, 10 segment 4
// - PC1..PC3 code 01 gives segments 9,19,20
// - PC4..PC7 code 01 gives segments 21..24
// - PD0..PD3 code 01 gives segments 25..28
// - PD4..PD7 code 01 gives segments 29..32
// - PE0..PE3 code 01: segments 33,34, commons 3,2
// - PE4,PE5 code 01: commons 1,0; top nibble zero
// - Share bit 1: segment 38 or common 5
// - Share bit 0: segment 39 or common 4
// - Share bits 7..2 read as zero
// - Reset sets port data and direction ones
// - Output switched before write drives high
// - Bit set/clear rewrites whole port byte
// - Port A falling edge wakes when enabled and LOW_POWER is high
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module pfs_top (
    input  wire logic        MCLK,
    input  wire logic        RESET,
    input  wire logic [3:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic        TIMER0_OUT,
    input  wire logic [39:0] SEG_DRIVE,
    input  wire logic [5:0]  COM_DRIVE,
    input  wire logic [7:0]  PA_IN,
    input  wire logic        LOW_POWER,
    output logic             WAKE,
    output logic [7:0]       PC_OUT,
    output logic [7:0]       PC_OE,
    output logic [7:0]       PD_OUT,
    output logic [7:0]       PD_OE,
    output logic [5:0]       PE_OUT,
    output logic [5:0]       PE_OE,
    output logic             SHARE38_OUT,
    output logic             SHARE39_OUT,
    output logic [3:0]       PC_SEG_FUNC,
    output logic [1:0]       SHARE_MODE
);
    import pfs_pkg::*;

    logic [7:0] port_c_function_select_low;
    logic [7:0] port_c_function_select_high;
    logic [7:0] port_d_function_select_low;
    logic [7:0] port_d_function_select_high;
    logic [7:0] port_e_function_select_low;
    logic [7:0] port_e_function_select_high;
    logic [7:0] lcd_common_segment_share;
    pfs_port_t  port_c;
    pfs_port_t  port_d;
    pfs_port_t  port_e;
    logic [7:0] wake_enable;
    logic [7:0] next_rdata;
    logic [7:0] bitop_old;
    logic [7:0] bitop_new;
    logic [2:0] bitop_idx;
    logic       bitop_wr;
    logic [3:0] bitop_addr;

    function automatic logic is_alt(input logic [15:0] sel, input int pin);
        return sel[pin*2 +: 2] == CODE_ALT;
    endfunction

    function automatic logic [7:0] read_reg(input logic [3:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_PC_SEL_LOW) begin
            v = port_c_function_select_low;
        end else if (a == ADDR_PC_SEL_HIGH) begin
            v = port_c_function_select_high;
        end else if (a == ADDR_PD_SEL_LOW) begin
            v = port_d_function_select_low;
        end else if (a == ADDR_PD_SEL_HIGH) begin
            v = port_d_function_select_high;
        end else if (a == ADDR_PE_SEL_LOW) begin
            v = port_e_function_select_low;
        end else if (a == ADDR_PE_SEL_HIGH) begin
            v = port_e_function_select_high & PE_HIGH_MASK;
        end else if (a == ADDR_SHARE) begin
            v = lcd_common_segment_share & SHARE_MASK;
        end else if (a == ADDR_PC_DATA) begin
            v = port_c.data;
        end else if (a == ADDR_PC_DIR) begin
            v = port_c.dir;
        end else if (a == ADDR_PD_DATA) begin
            v = port_d.data;
        end else if (a == ADDR_PD_DIR) begin
            v = port_d.dir;
        end else if (a == ADDR_PE_DATA) begin
            v = port_e.data & PE_MASK;
        end else if (a == ADDR_PE_DIR) begin
            v = port_e.dir & PE_MASK;
        end else if (a == ADDR_PA_WAKE_EN) begin
            v = wake_enable;
        end
        return v;
    endfunction

    // Bit set/clear: read the whole target byte, change one bit, write it all back
    always_comb begin
        bitop_addr = WDATA[3:0];
        bitop_idx  = WDATA[BITOP_IDX_POS +: 3];
        bitop_old  = read_reg(bitop_addr);
        bitop_new  = bitop_old;
        bitop_new[bitop_idx] = WDATA[BITOP_SET_POS];
        bitop_wr   = WR && (ADDR == ADDR_BIT_OP);
    end

    function automatic logic hits(input logic [3:0] a);
        return (WR && ADDR == a) || (bitop_wr && bitop_addr == a);
    endfunction

    function automatic logic [7:0] wval(input logic [3:0] a);
        return (bitop_wr && bitop_addr == a) ? bitop_new : WDATA;
    endfunction

    // Selection registers, effective the cycle after the write
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            port_c_function_select_low  <= SEL_RESET;
            port_c_function_select_high <= SEL_RESET;
            port_d_function_select_low  <= SEL_RESET;
            port_d_function_select_high <= SEL_RESET;
            port_e_function_select_low  <= SEL_RESET;
            port_e_function_select_high <= SEL_RESET;
            lcd_common_segment_share    <= SEL_RESET;
        end else begin
            if (hits(ADDR_PC_SEL_LOW))  port_c_function_select_low  <= wval(ADDR_PC_SEL_LOW);
            if (hits(ADDR_PC_SEL_HIGH)) port_c_function_select_high <= wval(ADDR_PC_SEL_HIGH);
            if (hits(ADDR_PD_SEL_LOW))  port_d_function_select_low  <= wval(ADDR_PD_SEL_LOW);
            if (hits(ADDR_PD_SEL_HIGH)) port_d_function_select_high <= wval(ADDR_PD_SEL_HIGH);
            if (hits(ADDR_PE_SEL_LOW))  port_e_function_select_low  <= wval(ADDR_PE_SEL_LOW);
            if (hits(ADDR_PE_SEL_HIGH)) port_e_function_select_high <= wval(ADDR_PE_SEL_HIGH) & PE_HIGH_MASK;
            if (hits(ADDR_SHARE))       lcd_common_segment_share    <= wval(ADDR_SHARE) & SHARE_MASK;
        end
    end

    // Port data and direction start at all ones so pins are inputs and outputs start high
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            port_c <= {PORT_RESET, PORT_RESET};
            port_d <= {PORT_RESET, PORT_RESET};
            port_e <= {PORT_RESET, PORT_RESET};
        end else begin
            if (hits(ADDR_PC_DATA)) port_c.data <= wval(ADDR_PC_DATA);
            if (hits(ADDR_PC_DIR))  port_c.dir  <= wval(ADDR_PC_DIR);
            if (hits(ADDR_PD_DATA)) port_d.data <= wval(ADDR_PD_DATA);
            if (hits(ADDR_PD_DIR))  port_d.dir  <= wval(ADDR_PD_DIR);
            if (hits(ADDR_PE_DATA)) port_e.data <= wval(ADDR_PE_DATA) | ~PE_MASK;
            if (hits(ADDR_PE_DIR))  port_e.dir  <= wval(ADDR_PE_DIR) | ~PE_MASK;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            wake_enable <= WAKE_RESET;
        end else if (hits(ADDR_PA_WAKE_EN)) begin
            wake_enable <= wval(ADDR_PA_WAKE_EN);
        end
    end

    always_comb begin
        next_rdata = read_reg(ADDR);
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // Alternate function routing
    logic [7:0] c_alt_sel;
    logic [7:0] c_alt_drv;
    logic [7:0] d_alt_sel;
    logic [7:0] d_alt_drv;
    logic [5:0] e_alt_sel;
    logic [5:0] e_alt_drv;
    logic [15:0] c_sel;
    logic [15:0] d_sel;
    logic [11:0] e_sel;

    always_comb begin
        c_sel = {port_c_function_select_high, port_c_function_select_low};
        d_sel = {port_d_function_select_high, port_d_function_select_low};
        e_sel = {port_e_function_select_high[3:0], port_e_function_select_low};
        c_alt_sel[0] = (c_sel[1:0] == CODE_ALT) || (c_sel[1:0] == CODE_ALT2);
        c_alt_drv[0] = (c_sel[1:0] == CODE_ALT) ? TIMER0_OUT : SEG_DRIVE[4];
        c_alt_sel[1] = is_alt(c_sel, 1);
        c_alt_drv[1] = SEG_DRIVE[9];
        c_alt_sel[2] = is_alt(c_sel, 2);
        c_alt_drv[2] = SEG_DRIVE[19];
        c_alt_sel[3] = is_alt(c_sel, 3);
        c_alt_drv[3] = SEG_DRIVE[20];
        for (int i = 4; i < 8; i++) begin
            c_alt_sel[i] = is_alt(c_sel, i);
            c_alt_drv[i] = SEG_DRIVE[17 + i];
        end
        for (int i = 0; i < 8; i++) begin
            d_alt_sel[i] = is_alt(d_sel, i);
            d_alt_drv[i] = SEG_DRIVE[25 + i];
        end
        for (int i = 0; i < 6; i++) begin
            e_alt_sel[i] = is_alt({4'h0, e_sel}, i);
        end
        e_alt_drv[0] = SEG_DRIVE[33];
        e_alt_drv[1] = SEG_DRIVE[34];
        e_alt_drv[2] = COM_DRIVE[3];
        e_alt_drv[3] = COM_DRIVE[2];
        e_alt_drv[4] = COM_DRIVE[1];
        e_alt_drv[5] = COM_DRIVE[0];
    end

    pfs_pin_t c_pin [8];
    pfs_pin_t d_pin [8];
    pfs_pin_t e_pin [6];

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pc
            pfs_gpio_pin u_c (
                .data_bit (port_c.data[g]),
                .dir_bit  (port_c.dir[g]),
                .alt_sel  (c_alt_sel[g]),
                .alt_drive(c_alt_drv[g]),
                .pin      (c_pin[g])
            );
            pfs_gpio_pin u_d (
                .data_bit (port_d.data[g]),
                .dir_bit  (port_d.dir[g]),
                .alt_sel  (d_alt_sel[g]),
                .alt_drive(d_alt_drv[g]),
                .pin      (d_pin[g])
            );
        end
        for (g = 0; g < 6; g++) begin : g_pe
            pfs_gpio_pin u_e (
                .data_bit (port_e.data[g]),
                .dir_bit  (port_e.dir[g]),
                .alt_sel  (e_alt_sel[g]),
                .alt_drive(e_alt_drv[g]),
                .pin      (e_pin[g])
            );
        end
    endgenerate

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            PC_OUT <= PORT_RESET;
            PC_OE  <= 8'h00;
            PD_OUT <= PORT_RESET;
            PD_OE  <= 8'h00;
            PE_OUT <= 6'h3f;
            PE_OE  <= 6'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                PC_OUT[i] <= c_pin[i].drive;
                PC_OE[i]  <= c_pin[i].out_en;
                PD_OUT[i] <= d_pin[i].drive;
                PD_OE[i]  <= d_pin[i].out_en;
            end
            for (int i = 0; i < 6; i++) begin
                PE_OUT[i] <= e_pin[i].drive;
                PE_OE[i]  <= e_pin[i].out_en;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            SHARE38_OUT <= 1'b0;
            SHARE39_OUT <= 1'b0;
            SHARE_MODE  <= 2'b00;
            PC_SEG_FUNC <= 4'h0;
        end else begin
            SHARE38_OUT <= lcd_common_segment_share[SHARE_LINE5_BIT] ? COM_DRIVE[5] : SEG_DRIVE[38];
            SHARE39_OUT <= lcd_common_segment_share[SHARE_LINE4_BIT] ? COM_DRIVE[4] : SEG_DRIVE[39];
            SHARE_MODE  <= lcd_common_segment_share[1:0];
            PC_SEG_FUNC <= c_alt_sel[3:0];
        end
    end

    pfs_wake_detect u_wake (
        .clk      (MCLK),
        .rst      (RESET),
        .pins     (PA_IN),
        .enable   (wake_enable),
        .low_power(LOW_POWER),
        .wake     (WAKE)
    );
endmodule
`default_nettype wire

// ### tb/pfs_checker.sv
// Purpose: Concurrent checks on pad routing, share pins and register reads of pfs_top
// Assumes: Selection bytes change only through writes to 0..6 or bit operations on them
// Notes:   Shadow of the selection bytes tells which source owns each pad
`timescale 1ns/1ns
`default_nettype none
module pfs_checker
    import pfs_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RESET,
    input wire logic [3:0]  ADDR,
    input wire logic [7:0]  WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic        TIMER0_OUT,
    input wire logic [39:0] SEG_DRIVE,
    input wire logic [5:0]  COM_DRIVE,
    input wire logic        LOW_POWER,
    input wire logic        WAKE,
    input wire logic [7:0]  PC_OUT,
    input wire logic [7:0]  PD_OUT,
    input wire logic [5:0]  PE_OUT,
    input wire logic        SHARE38_OUT,
    input wire logic        SHARE39_OUT
);
    logic [7:0] sel [7];

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            for (int k = 0; k < 7; k++) begin
                sel[k] <= 8'h00;
            end
        end else if (WR && ADDR < 4'h7) begin
            sel[ADDR[2:0]] <= WDATA;
        end else if (WR && ADDR == ADDR_BIT_OP && WDATA[3:0] < 4'h7) begin
            sel[WDATA[2:0]][WDATA[BITOP_IDX_POS +: 3]] <= WDATA[BITOP_SET_POS];
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    pc0_timer_a: assert property ($past(sel[0][1:0] == 2'b01) |-> PC_OUT[0] == $past(TIMER0_OUT))
        else $error("pc0 not carrying timer output");
    pc1_seg_a: assert property ($past(sel[0][3:2] == 2'b01) |-> PC_OUT[1] == $past(SEG_DRIVE[9]))
        else $error("pc1 not carrying segment 9");
    pc7_seg_a: assert property ($past(sel[1][7:6] == 2'b01) |-> PC_OUT[7] == $past(SEG_DRIVE[24]))
        else $error("pc7 not carrying segment 24");
    pd0_seg_a: assert property ($past(sel[2][1:0] == 2'b01) |-> PD_OUT[0] == $past(SEG_DRIVE[25]))
        else $error("pd0 not carrying segment 25");
    pd7_seg_a: assert property ($past(sel[3][7:6] == 2'b01) |-> PD_OUT[7] == $past(SEG_DRIVE[32]))
        else $error("pd7 not carrying segment 32");
    pe2_com_a: assert property ($past(sel[4][5:4] == 2'b01) |-> PE_OUT[2] == $past(COM_DRIVE[3]))
        else $error("pe2 not carrying common 3");
    pe5_com_a: assert property ($past(sel[5][3:2] == 2'b01) |-> PE_OUT[5] == $past(COM_DRIVE[0]))
        else $error("pe5 not carrying common 0");
    share38_route_a: assert property (!$past(RESET) |->
        SHARE38_OUT == ($past(sel[6][1]) ? $past(COM_DRIVE[5]) : $past(SEG_DRIVE[38])))
        else $error("shared pin 38 routed wrongly");
    share39_route_a: assert property (!$past(RESET) |->
        SHARE39_OUT == ($past(sel[6][0]) ? $past(COM_DRIVE[4]) : $past(SEG_DRIVE[39])))
        else $error("shared pin 39 routed wrongly");
    share_read_a: assert property ($past(RD && ADDR == ADDR_SHARE) |-> RDATA[7:2] == 6'h00)
        else $error("share register upper bits not zero");
    wake_idle_a: assert property (!$past(LOW_POWER) && !$past(LOW_POWER, 2) && !$past(LOW_POWER, 3) |-> !WAKE)
        else $error("wake raised outside low power");
endmodule

bind pfs_top pfs_checker i_chk (.MCLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .TIMER0_OUT, .SEG_DRIVE,
    .COM_DRIVE, .LOW_POWER, .WAKE, .PC_OUT, .PD_OUT, .PE_OUT, .SHARE38_OUT, .SHARE39_OUT);
`default_nettype wire

// ### tb/tb_pfs_top.sv
// Purpose: Self-checking bench for pfs_top
// Assumes: Sources stay still while pads are compared
// Notes:   Random register traffic from a fixed seed plus code corners
`timescale 1ns/1ns
`default_nettype none
module tb_pfs_top;
    import pfs_pkg::*;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        tmr = 1'b0;
    logic        low_power = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  pa_in = 8'hff;
    logic [39:0] seg = 40'h0;
    logic [5:0]  com = 6'h0;
    logic        wake, s38, s39;
    logic [7:0]  rdata, pc_out, pc_oe, pd_out, pd_oe;
    logic [5:0]  pe_out, pe_oe;
    logic [3:0]  pc_func;
    logic [1:0]  share_mode;
    logic [7:0]  sel [7];
    logic [7:0]  dat [3];
    logic [7:0]  dirr [3];
    logic [7:0]  wen;
    logic [63:0] rnd;
    logic [3:0]  tgt;
    logic [7:0]  codes [3] = '{8'h55, 8'haa, 8'hff};
    int          stab [3][8] = '{'{4, 9, 19, 20, 21, 22, 23, 24}, '{25, 26, 27, 28, 29, 30, 31, 32},
                                 '{33, 34, 103, 102, 101, 100, 0, 0}};
    int          seed = 32'h7e1e;
    int          miscompares = 0;
    int          comparisons = 0;

    pfs_top i_dut (.MCLK(mclk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr_stb), .RD(rd_stb),
        .RDATA(rdata), .TIMER0_OUT(tmr), .SEG_DRIVE(seg), .COM_DRIVE(com), .PA_IN(pa_in),
        .LOW_POWER(low_power), .WAKE(wake), .PC_OUT(pc_out), .PC_OE(pc_oe), .PD_OUT(pd_out),
        .PD_OE(pd_oe), .PE_OUT(pe_out), .PE_OE(pe_oe), .SHARE38_OUT(s38), .SHARE39_OUT(s39),
        .PC_SEG_FUNC(pc_func), .SHARE_MODE(share_mode));

    always #2 mclk = ~mclk;

    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic void mreset();
        for (int k = 0; k < 7; k++) begin
            sel[k] = SEL_RESET;
        end
        for (int k = 0; k < 3; k++) begin
            dat[k] = PORT_RESET;
            dirr[k] = PORT_RESET;
        end
        wen = WAKE_RESET;
    endfunction

    function automatic logic [7:0] rexp(input logic [3:0] a);
        case (a)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4: return sel[a[2:0]];
            ADDR_PE_SEL_HIGH: return sel[5] & PE_HIGH_MASK;
            ADDR_SHARE: return sel[6] & SHARE_MASK;
            4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd:
                return (a[0] ? dirr[a[2:1]] : dat[a[2:1]]) & (a[2:1] == 2'd2 ? PE_MASK : 8'hff);
            ADDR_PA_WAKE_EN: return wen;
            default: return 8'h00;
        endcase
    endfunction

    function automatic void mwr(input logic [3:0] a, input logic [7:0] d);
        if (a < 4'h7) begin
            sel[a[2:0]] = d;
        end else if (a == ADDR_PA_WAKE_EN) begin
            wen = d;
        end else if (a[3] && a < 4'he) begin
            if (a[0]) begin
                dirr[a[2:1]] = d;
            end else begin
                dat[a[2:1]] = d;
            end
        end
    endfunction

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] v;
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        if (a == ADDR_BIT_OP) begin
            v = rexp(d[3:0]);
            v[d[6:4]] = d[7];
            mwr(d[3:0], v);
        end else begin
            mwr(a, d);
        end
        @(posedge mclk);
    endtask

    task automatic bus_rd(input logic [3:0] a);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        chk("rdata", rexp(a), rdata);
        @(posedge mclk);
    endtask

    function automatic logic [2:0] pin_exp(input int p, input int i);
        logic [1:0] c;
        int         s;
        c = sel[2 * p + i / 4][2 * (i % 4) +: 2];
        s = stab[p][i];
        if (c == CODE_ALT && p == 0 && i == 0) return {2'b11, tmr};
        if (c == CODE_ALT2 && p == 0 && i == 0) return {2'b11, seg[4]};
        if (c == CODE_ALT) return {2'b11, s >= 100 ? com[s - 100] : seg[s]};
        return {1'b0, ~dirr[p][i], dat[p][i]};
    endfunction

    task automatic check_pads();
        logic [7:0] eo [3];
        logic [7:0] ee [3];
        logic [7:0] ea [3];
        logic [2:0] r;
        #1;
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 8; i++) begin
                r = pin_exp(p, i);
                ea[p][i] = r[2];
                ee[p][i] = r[1];
                eo[p][i] = r[0];
            end
        end
        chk("pc_out", eo[0], pc_out);
        chk("pc_oe", ee[0], pc_oe);
        chk("pc_func", {4'h0, ea[0][3:0]}, {4'h0, pc_func});
        chk("pd_out", eo[1], pd_out);
        chk("pd_oe", ee[1], pd_oe);
        chk("pe_out", {2'b00, eo[2][5:0]}, {2'b00, pe_out});
        chk("pe_oe", {2'b00, ee[2][5:0]}, {2'b00, pe_oe});
        chk("share38", {7'h00, sel[6][1] ? com[5] : seg[38]}, {7'h00, s38});
        chk("share39", {7'h00, sel[6][0] ? com[4] : seg[39]}, {7'h00, s39});
        chk("share_mode", {6'h00, sel[6][1:0]}, {6'h00, share_mode});
        @(posedge mclk);
    endtask

    task automatic drive_src();
        rnd = {$random(seed), $random(seed)};
        seg <= rnd[39:0];
        com <= rnd[45:40];
        tmr <= rnd[46];
        @(posedge mclk);
    endtask

    task automatic wake_seen(input logic e);
        logic hit;
        hit = 1'b0;
        repeat (8) begin
            @(posedge mclk);
            #1;
            hit = hit | wake;
        end
        chk("wake", {7'h00, e}, {7'h00, hit});
        @(posedge mclk);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        end_of_test();
    end

    initial begin
        mreset();
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        check_pads();
        for (int a = 0; a < 15; a++) bus_rd(4'(a));
        bus_wr(ADDR_PC_DIR, 8'h00);
        check_pads();
        // Function is chosen first, then the sources start to move
        for (int k = 0; k < 3; k++) begin
            for (int a = 0; a < 7; a++) bus_wr(4'(a), codes[k]);
            drive_src();
            check_pads();
        end
        for (int n = 0; n < 30; n++) begin
            for (int a = 0; a < 15; a++) begin
                rnd = {$random(seed), $random(seed)};
                bus_wr(4'(a), rnd[7:0]);
            end
            tgt = rnd[11:8];
            bus_wr(ADDR_BIT_OP, {rnd[15], rnd[14:12], tgt});
            drive_src();
            check_pads();
            for (int a = 0; a < 15; a++) bus_rd(4'(a));
        end
        bus_wr(ADDR_PA_WAKE_EN, 8'h08);
        low_power <= 1'b1;
        repeat (4) @(posedge mclk);
        pa_in <= 8'hf7;
        wake_seen(1'b1);
        pa_in <= 8'hff;
        repeat (4) @(posedge mclk);
        pa_in <= 8'hfe;
        wake_seen(1'b0);
        pa_in <= 8'hff;
        low_power <= 1'b0;
        repeat (4) @(posedge mclk);
        pa_in <= 8'hf7;
        wake_seen(1'b0);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        mreset();
        @(posedge mclk);
        check_pads();
        bus_rd(ADDR_SHARE);
        end_of_test();
    end
endmodule
`default_nettype wire
